//--- hdl/ppp_pkg.sv
// Package for the palette pixel pipeline: register map, mode codes and field layout
package ppp_pkg;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_WR_ADDR = 4'h1;
    localparam logic [3:0] REG_RD_ADDR = 4'h2;
    localparam logic [3:0] REG_DATA = 4'h3;
    localparam logic [3:0] REG_KEY = 4'h4;
    localparam logic [3:0] REG_KEY_MASK = 4'h5;
    localparam logic [3:0] REG_KEY_ZERO = 4'h6;
    localparam logic [3:0] REG_CUR_POS = 4'h7;
    localparam logic [3:0] REG_CUR_ADDR = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    localparam logic [31:0] BAD_READ = 32'h00000000;
    // Control register fields
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_DEPTH_LSB = 1;
    localparam int CTRL_ALPHA_BIT = 4;
    localparam int CTRL_ZOOM_LSB = 5;
    localparam int CTRL_READ_MASK_LSB = 8;
    localparam int CTRL_INTERLACE_BIT = 16;
    localparam logic [2:0] DEPTH_8 = 3'h0;
    localparam logic [2:0] DEPTH_15 = 3'h1;
    localparam logic [2:0] DEPTH_16 = 3'h2;
    localparam logic [2:0] DEPTH_24 = 3'h3;
    localparam logic [2:0] DEPTH_32DIR = 3'h4;
    localparam logic [2:0] DEPTH_32PAL = 3'h5;
    localparam logic [1:0] ZOOM_X1 = 2'h0;
    localparam logic [1:0] ZOOM_X2 = 2'h1;
    localparam logic [1:0] ZOOM_X4 = 2'h2;
    localparam logic [1:0] COMP_RED = 2'h0;
    localparam logic [1:0] COMP_GREEN = 2'h1;
    localparam logic [1:0] COMP_BLUE = 2'h2;
    localparam logic [6:0] CUR_SIZE = 7'h40;
    localparam logic [31:0] CTRL_RESET = 32'h0000ff00;
    typedef enum logic [2:0] {
        PPP_VGA, PPP_P8, PPP_T15, PPP_T16, PPP_T24, PPP_D32, PPP_P32
    } ppp_mode_t;
endpackage : ppp_pkg

//--- hdl/ppp_pipeline.sv
// Palette pixel pipeline: mode decode, palette RAMs, key, zoom, cursor overlay and register slave
//
// Contract
// - Extended bit 0 selects VGA; depth codes 0..5 pick the six extended modes.
// - VGA uses attribute byte, optionally read-masked, as common lookup address.
// - VGA shows no cursor, no keying and no horizontal zoom.
// - Pseudo colour uses FIFO bytes as common lookup address; cursor available.
// - 15-bit address is bit15, two zeros, then five colour bits per table.
// - 15-bit bit 15 is overlay select, forced zero when alpha enable is 0.
// - 16-bit splits 5:6:5 with leading zeros per table.
// - 24-bit and 32-bit palettized split bytes 23:16, 15:8, 7:0.
// - Packed 24-bit slices unpacked to whole pixels; 32-bit palettized drops top byte.
// - 32-bit direct bypasses tables with colour; alpha kept for keying.
// - Three 256x8 tables, one 8-bit address counter, modulo-3 component counter; the code keeps separate write and read address and component counters.
// - Data writes store at once; after blue, address increments, counter back to red.
// - After loading read address, three reads return one entry then advance.
// - Non-VGA cursor overlays everything, positioned from blank end, never zoomed.
// - Cursor pattern address taken from its registers with no double buffering.
// - Cursor position double-buffered, applied at vertical retrace end.
// - Interlaced odd Y puts even cursor rows in odd field; even Y swaps.
// - Interlaced Y below 64 draws row N on even field line 0.
// - Non-VGA keying compares masked index; 15-bit alpha bit per alpha enable.
// - 32-bit direct: alpha differs shows alpha; RGB equals key zero shows video.
// - Zoom x1, x2, x4 by duplication; fetch rate reduced to match.
// - Pixels replicated in the converter path while fetch advances slower.
//
// Our own choices: the Avalon-MM slave port and the register offsets.
module ppp_pipeline #(
    parameter int CUR_ADDR_W = 24
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic timing_extension_reg3_i,
    input wire logic [7:0] attribute_controller_i,
    input wire logic [31:0] fifo_data_i,
    input wire logic fifo_valid_i,
    output logic fifo_ready_o,
    input wire logic active_i,
    input wire logic hblank_end_i,
    input wire logic vretrace_i,
    input wire logic odd_field_i,
    input wire logic [1:0] cursor_pixel_i,
    input wire logic [11:0] cursor_x_i,
    input wire logic [11:0] line_y_i,
    input wire logic [7:0] scaler_r_i,
    input wire logic [7:0] scaler_g_i,
    input wire logic [7:0] scaler_b_i,
    output logic [23:0] rgb_o,
    output logic cursor_hit_o,
    output logic [5:0] cursor_row_o,
    output logic [CUR_ADDR_W-1:0] cursor_pattern_addr_o
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] wr_addr;
        logic [7:0] rd_addr;
        logic [1:0] wr_comp;
        logic [1:0] rd_comp;
        logic [7:0] key;
        logic [7:0] key_mask;
        logic [23:0] key_zero;
        logic [23:0] cur_pos_sh;
        logic [23:0] cur_pos;
        logic [CUR_ADDR_W-1:0] cur_addr;
        logic vr_q1;
        logic vr_q2;
        logic vr_q3;
        logic ack;
        logic rd_pend;
        logic [31:0] rdata;
        logic [1:0] zcnt;
        logic [1:0] p24_ph;
        logic [23:0] p24_hold;
        logic [31:0] pix;
        logic [7:0] ar;
        logic [7:0] ag;
        logic [7:0] ab;
        logic [1:0] sel;
        logic [23:0] direct;
        logic [23:0] rgb;
        logic hit;
        logic [5:0] row;
    } ppp_state_t;

    localparam logic [1:0] SEL_LUT = 2'h0;
    localparam logic [1:0] SEL_DIRECT = 2'h1;
    localparam logic [1:0] SEL_SCALER = 2'h2;
    localparam logic [1:0] SEL_ALPHA = 2'h3;

    ppp_state_t st;
    ppp_state_t next_st;
    ppp_pkg::ppp_mode_t mode;

    // Palette tables; host port and pixel port read the same arrays
    logic [7:0] lut_r [256];
    logic [7:0] lut_g [256];
    logic [7:0] lut_b [256];
    logic lut_we;

    always_comb begin
        if (!timing_extension_reg3_i) begin
            mode = ppp_pkg::PPP_VGA;
        end else begin
            unique case (st.ctrl[ppp_pkg::CTRL_DEPTH_LSB +: 3])
                ppp_pkg::DEPTH_8: mode = ppp_pkg::PPP_P8;
                ppp_pkg::DEPTH_15: mode = ppp_pkg::PPP_T15;
                ppp_pkg::DEPTH_16: mode = ppp_pkg::PPP_T16;
                ppp_pkg::DEPTH_24: mode = ppp_pkg::PPP_T24;
                ppp_pkg::DEPTH_32DIR: mode = ppp_pkg::PPP_D32;
                ppp_pkg::DEPTH_32PAL: mode = ppp_pkg::PPP_P32;
                default: mode = ppp_pkg::PPP_P8;
            endcase
        end
    end

    logic alpha_en;
    logic [1:0] zoom;
    logic [7:0] rmask;
    logic interlace;
    logic vga;
    logic [1:0] zlim;
    logic take;
    logic [31:0] pix_in;
    logic [7:0] idx;
    logic [7:0] kmask_fmt;
    logic key_hit;
    logic [11:0] cy;
    logic [11:0] cx;
    logic [11:0] dy;
    logic [12:0] dy_il;
    logic in_rows;
    logic in_cols;

    always_comb begin
        alpha_en = st.ctrl[ppp_pkg::CTRL_ALPHA_BIT];
        zoom = st.ctrl[ppp_pkg::CTRL_ZOOM_LSB +: 2];
        rmask = st.ctrl[ppp_pkg::CTRL_READ_MASK_LSB +: 8];
        interlace = st.ctrl[ppp_pkg::CTRL_INTERLACE_BIT];
        vga = (mode == ppp_pkg::PPP_VGA);
        // Replication count less one; the fetch slows by the replication factor
        unique case (vga ? ppp_pkg::ZOOM_X1 : zoom)
            ppp_pkg::ZOOM_X2: zlim = 2'h1;
            ppp_pkg::ZOOM_X4: zlim = 2'h3;
            default: zlim = 2'h0;
        endcase
        take = active_i && (st.zcnt == zlim);
        pix_in = fifo_data_i;
        cx = st.cur_pos[11:0];
        cy = st.cur_pos[23:12];
        dy = line_y_i - cy;
        dy_il = {line_y_i, 1'b0} - {1'b0, cy};
        // Interlaced line L shows display line 2L+field
        if (interlace) begin
            dy_il = dy_il + {12'h000, ~odd_field_i ^ 1'b1};
            in_rows = (dy_il < 13'(ppp_pkg::CUR_SIZE)) || (cy < 12'(ppp_pkg::CUR_SIZE));
        end else begin
            in_rows = (dy < 12'(ppp_pkg::CUR_SIZE));
        end
        in_cols = (cursor_x_i >= cx) && (cursor_x_i - cx < 12'(ppp_pkg::CUR_SIZE));
        idx = st.ar;
        kmask_fmt = st.key_mask;
        if (mode == ppp_pkg::PPP_T15 && !alpha_en) begin
            kmask_fmt[7] = 1'b0;
        end
        key_hit = ((idx ^ st.key) & kmask_fmt) == 8'h00;
    end

    always_comb begin
        next_st = st;
        lut_we = 1'b0;
        // Position shadow moves to the live copy at vertical retrace end
        next_st.vr_q1 = vretrace_i;
        next_st.vr_q2 = st.vr_q1;
        next_st.vr_q3 = st.vr_q2;
        if (st.vr_q3 && !st.vr_q2) begin
            next_st.cur_pos = st.cur_pos_sh;
        end
        // Register slave: one wait cycle, then ack
        next_st.ack = 1'b0;
        if ((avs_read_i || avs_write_i) && !st.ack) begin
            next_st.ack = 1'b1;
            if (avs_write_i) begin
                unique case (avs_address_i)
                    ppp_pkg::REG_CTRL: next_st.ctrl = avs_writedata_i;
                    ppp_pkg::REG_WR_ADDR: begin
                        next_st.wr_addr = avs_writedata_i[7:0];
                        next_st.wr_comp = ppp_pkg::COMP_RED;
                    end
                    ppp_pkg::REG_RD_ADDR: begin
                        next_st.rd_addr = avs_writedata_i[7:0];
                        next_st.rd_comp = ppp_pkg::COMP_RED;
                    end
                    ppp_pkg::REG_DATA: begin
                        lut_we = 1'b1;
                        if (st.wr_comp == ppp_pkg::COMP_BLUE) begin
                            next_st.wr_comp = ppp_pkg::COMP_RED;
                            next_st.wr_addr = st.wr_addr + 8'h01;
                        end else begin
                            next_st.wr_comp = st.wr_comp + 2'h1;
                        end
                    end
                    ppp_pkg::REG_KEY: next_st.key = avs_writedata_i[7:0];
                    ppp_pkg::REG_KEY_MASK: next_st.key_mask = avs_writedata_i[7:0];
                    ppp_pkg::REG_KEY_ZERO: next_st.key_zero = avs_writedata_i[23:0];
                    ppp_pkg::REG_CUR_POS: next_st.cur_pos_sh = avs_writedata_i[23:0];
                    ppp_pkg::REG_CUR_ADDR: next_st.cur_addr = avs_writedata_i[CUR_ADDR_W-1:0];
                    default: ;
                endcase
            end else begin
                unique case (avs_address_i)
                    ppp_pkg::REG_CTRL: next_st.rdata = st.ctrl;
                    ppp_pkg::REG_WR_ADDR: next_st.rdata = {24'h000000, st.wr_addr};
                    ppp_pkg::REG_RD_ADDR: next_st.rdata = {24'h000000, st.rd_addr};
                    ppp_pkg::REG_DATA: begin
                        unique case (st.rd_comp)
                            ppp_pkg::COMP_RED: next_st.rdata = {24'h000000, lut_r[st.rd_addr]};
                            ppp_pkg::COMP_GREEN: next_st.rdata = {24'h000000, lut_g[st.rd_addr]};
                            default: next_st.rdata = {24'h000000, lut_b[st.rd_addr]};
                        endcase
                        if (st.rd_comp == ppp_pkg::COMP_BLUE) begin
                            next_st.rd_comp = ppp_pkg::COMP_RED;
                            next_st.rd_addr = st.rd_addr + 8'h01;
                        end else begin
                            next_st.rd_comp = st.rd_comp + 2'h1;
                        end
                    end
                    ppp_pkg::REG_KEY: next_st.rdata = {24'h000000, st.key};
                    ppp_pkg::REG_KEY_MASK: next_st.rdata = {24'h000000, st.key_mask};
                    ppp_pkg::REG_KEY_ZERO: next_st.rdata = {8'h00, st.key_zero};
                    ppp_pkg::REG_CUR_POS: next_st.rdata = {8'h00, st.cur_pos_sh};
                    ppp_pkg::REG_CUR_ADDR: next_st.rdata = 32'(st.cur_addr);
                    ppp_pkg::REG_STATUS: next_st.rdata = {29'h00000000, st.vr_q2, st.wr_comp == 2'h0, vga};
                    default: next_st.rdata = ppp_pkg::BAD_READ;
                endcase
            end
        end
        // Pixel front end: zoom counter and packed 24-bit unpacker
        if (active_i) begin
            next_st.zcnt = take ? 2'h0 : st.zcnt + 2'h1;
        end else begin
            next_st.zcnt = 2'h0;
            next_st.p24_ph = 2'h0;
        end
        if (take && fifo_valid_i) begin
            if (mode == ppp_pkg::PPP_T24) begin
                // Three words carry four pixels; the leftover bytes wait in p24_hold
                unique case (st.p24_ph)
                    2'h0: begin
                        next_st.pix = {8'h00, pix_in[23:0]};
                        next_st.p24_hold = {16'h0000, pix_in[31:24]};
                    end
                    2'h1: begin
                        next_st.pix = {8'h00, pix_in[15:0], st.p24_hold[7:0]};
                        next_st.p24_hold = {8'h00, pix_in[31:16]};
                    end
                    2'h2: begin
                        next_st.pix = {8'h00, pix_in[7:0], st.p24_hold[15:0]};
                        next_st.p24_hold = pix_in[31:8];
                    end
                    default: next_st.pix = {8'h00, st.p24_hold};
                endcase
                next_st.p24_ph = st.p24_ph + 2'h1;
            end else begin
                next_st.pix = pix_in;
            end
        end else if (take && mode == ppp_pkg::PPP_T24 && st.p24_ph == 2'h3) begin
            next_st.pix = {8'h00, st.p24_hold};
            next_st.p24_ph = 2'h0;
        end
        // Lookup address formation
        unique case (mode)
            ppp_pkg::PPP_VGA: begin
                next_st.ar = attribute_controller_i & rmask;
                next_st.ag = attribute_controller_i & rmask;
                next_st.ab = attribute_controller_i & rmask;
            end
            ppp_pkg::PPP_P8: begin
                next_st.ar = st.pix[7:0];
                next_st.ag = st.pix[7:0];
                next_st.ab = st.pix[7:0];
            end
            ppp_pkg::PPP_T15: begin
                next_st.ar = {st.pix[15] & alpha_en, 2'h0, st.pix[14:10]};
                next_st.ag = {st.pix[15] & alpha_en, 2'h0, st.pix[9:5]};
                next_st.ab = {st.pix[15] & alpha_en, 2'h0, st.pix[4:0]};
            end
            ppp_pkg::PPP_T16: begin
                next_st.ar = {3'h0, st.pix[15:11]};
                next_st.ag = {2'h0, st.pix[10:5]};
                next_st.ab = {3'h0, st.pix[4:0]};
            end
            ppp_pkg::PPP_D32: begin
                next_st.ar = st.pix[31:24];
                next_st.ag = st.pix[31:24];
                next_st.ab = st.pix[31:24];
            end
            default: begin
                next_st.ar = st.pix[23:16];
                next_st.ag = st.pix[15:8];
                next_st.ab = st.pix[7:0];
            end
        endcase
        next_st.direct = st.pix[23:0];
        // Output select: key decisions then lookup or direct
        if (mode == ppp_pkg::PPP_D32) begin
            if (!key_hit) begin
                next_st.sel = SEL_ALPHA;
            end else if (st.direct == st.key_zero) begin
                next_st.sel = SEL_SCALER;
            end else begin
                next_st.sel = SEL_DIRECT;
            end
        end else if (!vga && key_hit) begin
            next_st.sel = SEL_SCALER;
        end else begin
            next_st.sel = SEL_LUT;
        end
        unique case (st.sel)
            SEL_DIRECT: next_st.rgb = st.direct;
            SEL_SCALER: next_st.rgb = {scaler_r_i, scaler_g_i, scaler_b_i};
            SEL_ALPHA: next_st.rgb = {lut_r[st.ar], lut_g[st.ar], lut_b[st.ar]};
            default: next_st.rgb = {lut_r[st.ar], lut_g[st.ag], lut_b[st.ab]};
        endcase
        // Cursor sits above all else, in unzoomed pixel coordinates from blank end
        next_st.hit = !vga && in_rows && in_cols && cursor_pixel_i != 2'h0;
        next_st.row = interlace ? dy_il[5:0] : dy[5:0];
        if (st.hit) begin
            next_st.rgb = cursor_pixel_i[1] ? 24'hffffff : 24'h000000;
        end
        if (hblank_end_i) begin
            next_st.row = st.row;
        end
    end

    always_ff @(posedge clock_i) begin
        if (lut_we) begin
            unique case (st.wr_comp)
                ppp_pkg::COMP_RED: lut_r[st.wr_addr] <= avs_writedata_i[7:0];
                ppp_pkg::COMP_GREEN: lut_g[st.wr_addr] <= avs_writedata_i[7:0];
                default: lut_b[st.wr_addr] <= avs_writedata_i[7:0];
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.ctrl <= ppp_pkg::CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = !st.ack;
    // The fourth packed pixel comes from held bytes, so no word is taken then
    assign fifo_ready_o = take && !(mode == ppp_pkg::PPP_T24 && st.p24_ph == 2'h3);
    assign rgb_o = st.rgb;
    assign cursor_hit_o = st.hit;
    assign cursor_row_o = st.row;
    assign cursor_pattern_addr_o = st.cur_addr;

    property p_wr_wrap;
        @(posedge clock_i) disable iff (sys_rst_i)
        (lut_we && st.wr_comp == ppp_pkg::COMP_BLUE) |=> (st.wr_comp == ppp_pkg::COMP_RED) &&
            (st.wr_addr == $past(st.wr_addr) + 8'h01);
    endproperty
    a_wr_wrap: assert property (p_wr_wrap) else $error("write counter did not wrap");
    property p_comp_range;
        @(posedge clock_i) disable iff (sys_rst_i) st.wr_comp != 2'h3 && st.rd_comp != 2'h3;
    endproperty
    a_comp_range: assert property (p_comp_range) else $error("component counter out of range");
    property p_vga_nocur;
        @(posedge clock_i) disable iff (sys_rst_i) vga |=> !st.hit;
    endproperty
    a_vga_nocur: assert property (p_vga_nocur) else $error("cursor shown in vga mode");
    property p_pos_hold;
        @(posedge clock_i) disable iff (sys_rst_i) !(st.vr_q3 && !st.vr_q2) |=> $stable(st.cur_pos);
    endproperty
    a_pos_hold: assert property (p_pos_hold) else $error("cursor position changed outside retrace end");
    property p_vga_addr;
        @(posedge clock_i) disable iff (sys_rst_i)
        vga |=> st.ar == ($past(attribute_controller_i) & $past(rmask));
    endproperty
    a_vga_addr: assert property (p_vga_addr) else $error("vga lookup address wrong");
    property p_ack;
        @(posedge clock_i) disable iff (sys_rst_i) (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    c_wr_wrap: cover property (@(posedge clock_i) lut_we && st.wr_comp == ppp_pkg::COMP_BLUE);
    c_scaler: cover property (@(posedge clock_i) st.sel == SEL_SCALER);
    c_cursor: cover property (@(posedge clock_i) st.hit);
endmodule : ppp_pipeline

//--- testbench/ppp_partner.sv
// Far-side model: pixel FIFO feeder and display timing source
module ppp_partner (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] slice_i,
    input wire logic feed_i,
    input wire logic fifo_ready_i,
    output logic [31:0] fifo_data_o,
    output logic fifo_valid_o,
    output logic hblank_end_o,
    output logic [11:0] cursor_x_o,
    output logic [11:0] line_y_o,
    output logic [31:0] taken_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cursor_x_o <= 12'h000;
            line_y_o <= 12'h000;
            taken_o <= 32'h0;
            last <= 32'h0;
        end else begin
            cursor_x_o <= (cursor_x_o == 12'h03f) ? 12'h000 : cursor_x_o + 12'h001;
            if (cursor_x_o == 12'h03f) line_y_o <= line_y_o + 12'h001;
            if (fifo_ready_i && fifo_valid_o) taken_o <= taken_o + 32'h1;
            last <= fifo_data_o;
        end
    end
    // Line of 64 clocks leaves blanking long enough for the cursor fetch
    assign hblank_end_o = (cursor_x_o == 12'h03f);
    // An idle FIFO shows no stale slice: the data toggles every cycle
    assign fifo_valid_o = feed_i;
    assign fifo_data_o = feed_i ? slice_i : ~last;
endmodule : ppp_partner

//--- testbench/palette_pixel_pipeline_test.sv
// Self-checking bench for the palette pixel pipeline
module palette_pixel_pipeline_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0, ext = 1'b0, feed = 1'b0, vr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, fdata, slice = 32'h0, q, rd_s, taken, p, v0;
    logic wreq, wait_s, fvalid, fready, hbe, hit;
    logic [7:0] attr = 8'h00, sr = 8'h00, sg = 8'h00, sb = 8'h00;
    logic [1:0] curpix = 2'h0;
    logic [11:0] cx, ly;
    logic [23:0] rgb, v;
    logic [5:0] crow;
    logic [23:0] caddr;
    int seed, mismatches, tests_run, i, j;
    always #5 clock_i = ~clock_i;
    always @(negedge clock_i) begin
        wait_s = wreq;
        rd_s = rdata;
    end
    ppp_pipeline u_ppp_pipeline (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
        .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .timing_extension_reg3_i(ext),
        .attribute_controller_i(attr), .fifo_data_i(fdata), .fifo_valid_i(fvalid), .fifo_ready_o(fready),
        .active_i(1'b1), .hblank_end_i(hbe), .vretrace_i(vr), .odd_field_i(1'b0), .cursor_pixel_i(curpix),
        .cursor_x_i(cx), .line_y_i(ly), .scaler_r_i(sr), .scaler_g_i(sg), .scaler_b_i(sb), .rgb_o(rgb),
        .cursor_hit_o(hit), .cursor_row_o(crow), .cursor_pattern_addr_o(caddr));
    ppp_partner u_ppp_partner (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slice_i(slice), .feed_i(feed),
        .fifo_ready_i(fready), .fifo_data_o(fdata), .fifo_valid_o(fvalid), .hblank_end_o(hbe),
        .cursor_x_o(cx), .line_y_o(ly), .taken_o(taken));
    function automatic logic [23:0] pal3(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        return {r ^ 8'h5a, g + 8'h33, ~b};
    endfunction : pal3
    function automatic logic [23:0] exp_px(input logic [2:0] d, input logic al, input logic [31:0] x);
        logic t;
        t = al & x[15];
        case (d)
            ppp_pkg::DEPTH_15: return pal3({t, 2'h0, x[14:10]}, {t, 2'h0, x[9:5]}, {t, 2'h0, x[4:0]});
            ppp_pkg::DEPTH_16: return pal3({3'h0, x[15:11]}, {2'h0, x[10:5]}, {3'h0, x[4:0]});
            ppp_pkg::DEPTH_32PAL: return pal3(x[23:16], x[15:8], x[7:0]);
            default: return pal3(x[7:0], x[7:0], x[7:0]);
        endcase
    endfunction : exp_px
    task automatic tally_and_finish;
        $display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("BAD at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        wr_i <= w;
        rd_i <= ~w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (wait_s !== 1'b0 && n < 20);
        q = rd_s;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            $display("BAD at %0t: bus answer timeout", $time);
            tally_and_finish();
        end
    endtask : bus
    task automatic show(input logic [31:0] s, input logic [23:0] want, input string what);
        @(posedge clock_i);
        slice <= s;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        check({8'h0, rgb}, {8'h0, want}, what);
    endtask : show
    initial begin
        seed = 33731;
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        bus(0, ppp_pkg::REG_CTRL, 32'h0);
        check(q, ppp_pkg::CTRL_RESET, "ctrl reset value");
        bus(0, 4'hf, 32'h0);
        check(q, ppp_pkg::BAD_READ, "unmapped read");
        bus(1, ppp_pkg::REG_KEY, 32'hffffffff);
        bus(1, ppp_pkg::REG_KEY_MASK, 32'hffffffff);
        bus(1, ppp_pkg::REG_WR_ADDR, 32'h0);
        for (i = 0; i < 256; i++) begin
            v = pal3(i[7:0], i[7:0], i[7:0]);
            for (j = 0; j < 3; j++) bus(1, ppp_pkg::REG_DATA, {24'h0, v[23 - 8 * j -: 8]});
        end
        p = $random(seed);
        bus(1, ppp_pkg::REG_RD_ADDR, {24'h0, p[7:0]});
        for (i = 0; i < 6; i++) begin
            bus(0, ppp_pkg::REG_DATA, 32'h0);
            v = pal3(p[7:0] + i / 3, p[7:0] + i / 3, p[7:0] + i / 3);
            check(q, {24'h0, v[23 - 8 * (i % 3) -: 8]}, "palette read back");
        end
        $display("palette access test finished");
        bus(1, ppp_pkg::REG_CTRL, 32'h00000f00);
        curpix <= 2'h2;
        for (i = 0; i < 4; i++) begin
            p = $random(seed);
            attr <= p[7:0];
            show(32'h0, pal3(p[7:0] & 8'h0f, p[7:0] & 8'h0f, p[7:0] & 8'h0f), "vga masked lookup");
            check({31'h0, hit}, 32'h0, "vga cursor shown");
        end
        curpix <= 2'h0;
        ext <= 1'b1;
        feed <= 1'b1;
        $display("vga test finished");
        for (i = 0; i < 8; i++) begin
            v0 = 32'h0;
            v0[3:1] = (i[2:1] == 2'h3) ? ppp_pkg::DEPTH_32PAL : {1'b0, i[2:1]};
            v0[4] = i[0];
            v0[15:8] = 8'hff;
            bus(1, ppp_pkg::REG_CTRL, {16'h0, v0[15:0]});
            p = $random(seed) & 32'hfefefefe;
            if (v0[3:1] == ppp_pkg::DEPTH_8) p = {4{p[7:0]}};
            if (v0[3:1] != ppp_pkg::DEPTH_32PAL && v0[3:1] != ppp_pkg::DEPTH_8) p = {2{p[15:0]}};
            show(p, exp_px(v0[3:1], v0[4], p), "pixel mapping");
        end
        show(32'h00ffffff, 24'h000000, "palette key selects video");
        $display("mode mapping test finished");
        bus(1, ppp_pkg::REG_CTRL, {16'h0, 8'hff, 4'h0, ppp_pkg::DEPTH_32DIR, 1'b0});
        p = $random(seed) & 32'hfefefefe;
        show(p, pal3(p[31:24], p[31:24], p[31:24]), "direct alpha shown");
        p[31:24] = 8'hff;
        bus(1, ppp_pkg::REG_KEY_ZERO, {8'h0, p[23:0] ^ 24'h1});
        show(p, p[23:0], "direct colour bypass");
        bus(1, ppp_pkg::REG_KEY_ZERO, {8'h0, p[23:0]});
        sr <= p[7:0] ^ 8'h3c;
        sg <= p[15:8];
        sb <= 8'h81;
        show(p, {p[7:0] ^ 8'h3c, p[15:8], 8'h81}, "direct key zero video");
        $display("direct colour test finished");
        bus(1, ppp_pkg::REG_CTRL, {16'h0, 8'hff, 4'h0, ppp_pkg::DEPTH_24, 1'b0});
        p = {4{p[7:0]}};
        show(p, pal3(p[7:0], p[7:0], p[7:0]), "packed 24-bit pixels");
        q = taken;
        repeat (64) @(posedge clock_i);
        @(negedge clock_i);
        j = taken - q - 48;
        check({31'h0, j >= -1 && j <= 1}, 32'h1, "packed 24-bit fetch rate");
        for (i = 0; i < 3; i++) begin
            bus(1, ppp_pkg::REG_CTRL, {16'h0, 8'hff, 1'b0, i[1:0], 1'b0, ppp_pkg::DEPTH_32PAL, 1'b1});
            repeat (4) @(posedge clock_i);
            @(negedge clock_i);
            q = taken;
            repeat (64) @(posedge clock_i);
            @(negedge clock_i);
            j = taken - q - (64 >> i);
            check({31'h0, j >= -1 && j <= 1}, 32'h1, "zoom fetch rate");
        end
        p = $random(seed);
        bus(1, ppp_pkg::REG_CUR_ADDR, p);
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check({8'h0, caddr}, {8'h0, p[23:0]}, "cursor pattern address");
        bus(1, ppp_pkg::REG_CUR_POS, 32'h00800000);
        curpix <= 2'h3;
        repeat (4) @(negedge clock_i);
        for (j = 0; j < 64 && cx != 12'h020; j++) @(negedge clock_i);
        check({31'h0, hit}, 32'h1, "cursor before retrace end");
        check({8'h0, rgb}, 32'h00ffffff, "cursor over graphics");
        check({26'h0, crow}, {26'h0, ly[5:0]}, "cursor row");
        @(posedge clock_i);
        vr <= 1'b1;
        repeat (4) @(posedge clock_i);
        vr <= 1'b0;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        check({31'h0, hit}, 32'h0, "cursor moved at retrace end");
        $display("zoom and cursor test finished");
        tally_and_finish();
    end
endmodule : palette_pixel_pipeline_test
